// File: src/sdreg_pkg.sv
// Constants, register selects and field encodings for the card register bank.
// Assumes a command decoder on the same clock that issues read and write requests.
// ****************************************************************************
// Summary of operation
// ****************************************************************************
// Summary of operation
// - A 32-bit operating-conditions word reports the supported voltage window and the power-up busy flag.
// - Bit 31 of that word reads 0 while busy and turns 1 only once power-up and initialization are complete.
// - Bits 23 to 15 all read 1, one bit for each 0.1 V slice from 2.7 V to 3.6 V.
// - Bit 24, the low-voltage switch accepted flag, reads 0.
// - Every reserved bit of the operating-conditions word reads 0, bit 7 and bits 29 to 25 and 14 to 0 included.
// - A 128-bit identity word holds maker code, OEM code, product name, revision and serial number from the top.
// - Identity bits 23 to 20 read 0, and the date and serial number fields are set per production lot.
// - Identity bits 7 to 1 hold a 7-bit checksum over the identity contents and bit 0 reads 1.
// - A 128-bit card-specific data word describes access characteristics and capabilities.
// - Only the writable fields of the card-specific data word change, and only through the program command.
// - The 16-bit driver-stage register is not implemented, so driver strength cannot be programmed.
// - A 64-bit configuration word describes the special features of the card.
// - A 512-bit status block carries status bits and card feature information.
// - A 16-bit relative address register, written during identification, selects the card on the bus.
package sdreg_pkg;

  typedef enum logic [2:0] {
    SDREG_SEL_OCR,
    SDREG_SEL_CID,
    SDREG_SEL_CSD,
    SDREG_SEL_RCA,
    SDREG_SEL_DSR,
    SDREG_SEL_CFG,
    SDREG_SEL_STAT
  } sdreg_sel_t;

  // ****************************************************************************
  // Operating-conditions word
  // ****************************************************************************
  localparam int OCR_W = 32;
  localparam int OCR_BUSY_BIT = 31;
  localparam int OCR_CCS_BIT = 30;
  localparam int OCR_LOW_VOLTAGE_SWITCH_ACCEPTED_BIT = 24;
  localparam int OCR_WIN_HI = 23;
  localparam int OCR_WIN_LO = 15;
  localparam logic OCR_CCS_VAL = 1'h0;
  localparam logic OCR_LOW_VOLTAGE_SWITCH_ACCEPTED_VAL = 1'h0;
  localparam logic [8:0] OCR_WIN_VAL = 9'h1ff;
  localparam logic [OCR_W-1:0] OCR_RESET = 32'h0000_0000;

  // ****************************************************************************
  // Identity word
  // ****************************************************************************
  localparam int CID_W = 128;
  localparam int CID_BODY_W = 120;
  localparam logic [3:0] CID_GAP_VAL = 4'h0;
  localparam logic CID_END_BIT = 1'h1;
  localparam int CRC_W = 7;
  localparam logic [CRC_W-1:0] CRC7_POLY = 7'h09;
  localparam logic [CRC_W-1:0] CRC7_INIT = 7'h00;
  localparam logic [6:0] CRC_CNT_INIT = 7'h00;
  localparam logic [6:0] CRC_CNT_LAST = 7'h78;

  // ****************************************************************************
  // Card-specific data word
  // ****************************************************************************
  localparam int CSD_W = 128;
  localparam int CSD_TMP_BIT = 12;
  localparam int CSD_PERM_BIT = 13;
  localparam int CSD_COPY_BIT = 14;
  localparam int CSD_CRC_LO = 1;
  localparam int CSD_CRC_HI = 7;
  localparam logic [CSD_W-1:0] CSD_WR_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_70fe;
  localparam logic [1:0] CSD_STRUCT_VAL = 2'h1;
  localparam logic [7:0] CSD_ACCESS_TIME_CODE_VAL = 8'h0e;
  localparam logic [7:0] CSD_NSAC_VAL = 8'h00;
  localparam logic [7:0] CSD_SPEED_VAL = 8'h32;
  localparam logic [11:0] CSD_CCC_VAL = 12'h5b5;
  localparam logic [3:0] CSD_RBL_VAL = 4'h9;
  localparam logic [3:0] CSD_WBL_VAL = 4'h9;
  localparam logic [2:0] CSD_R2W_VAL = 3'h2;
  localparam logic CSD_ERASE_VAL = 1'h1;
  localparam logic [6:0] CSD_SECTOR_VAL = 7'h7f;
  localparam logic [6:0] CSD_WPGRP_VAL = 7'h00;

  // ****************************************************************************
  // Other words
  // ****************************************************************************
  localparam int RCA_W = 16;
  localparam logic [RCA_W-1:0] RCA_RESET = 16'h0000;
  localparam int CFG_W = 64;
  localparam int STAT_W = 512;
  localparam int STAT_CHUNKS = 4;
  localparam logic [CID_W-1:0] DATA_ZERO = 128'h0;

endpackage

// File: src/sdreg_bank.sv
// Card-side identification and configuration register bank.
// Assumes requests come from a command decoder on core_clk; init_done comes from the init sequencer.
`timescale 1ns/1ps
module sdreg_bank #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,        // Arbitrary value
  parameter logic [15:0] OEM_CODE = 16'h4142,      // Arbitrary value
  parameter logic [39:0] PRODUCT_NAME = 40'h4e41_4e44_30,
  parameter logic [7:0] PRODUCT_REV = 8'h10,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter logic [11:0] MANUFACTURE_DATE = 12'h000,
  parameter logic [21:0] CAPACITY_SIZE = 22'h00_0000,
  parameter logic [6:0] CSD_CRC_INIT = 7'h00,
  parameter logic [63:0] CONFIG_VALUE = 64'h0000_0000_0000_0000,
  parameter logic [511:0] STATUS_VALUE = 512'h0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Initialization progress
  input wire logic init_done,
  // Read requests
  input wire logic rd_req,
  input wire sdreg_pkg::sdreg_sel_t rd_sel,
  input wire logic [1:0] rd_index,
  output logic rd_valid,
  output logic rd_refused,
  output logic [sdreg_pkg::CID_W-1:0] rd_data,
  // Write requests
  input wire logic wr_req,
  input wire sdreg_pkg::sdreg_sel_t wr_sel,
  input wire logic [sdreg_pkg::CSD_W-1:0] wr_data,
  output logic wr_done,
  output logic wr_error,
  // Register views
  output logic [sdreg_pkg::OCR_W-1:0] operating_conditions_reg,
  output logic [sdreg_pkg::RCA_W-1:0] relative_address_reg,
  output logic id_check_ready
);
  import sdreg_pkg::*;

  // ****************************************************************************
  // Fixed words
  // ****************************************************************************
  logic [CID_BODY_W-1:0] cid_body;
  logic [CSD_W-1:0] csd_fixed;
  logic [OCR_W-1:0] ocr_ready;
  logic [CID_W-1:0] card_identity_reg;
  logic [CSD_W-1:0] card_specific_data_reg;
  logic [CFG_W-1:0] card_config_reg;

  assign cid_body = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV, SERIAL_NUMBER,
                     CID_GAP_VAL, MANUFACTURE_DATE};
  assign csd_fixed = {CSD_STRUCT_VAL, 6'h00, CSD_ACCESS_TIME_CODE_VAL, CSD_NSAC_VAL, CSD_SPEED_VAL, CSD_CCC_VAL,
                      CSD_RBL_VAL, 4'h0, 6'h00, CAPACITY_SIZE, 1'h0, CSD_ERASE_VAL, CSD_SECTOR_VAL,
                      CSD_WPGRP_VAL, 1'h0, 2'h0, CSD_R2W_VAL, CSD_WBL_VAL, 1'h0, 5'h00, 1'h0,
                      3'h0, 2'h0, 2'h0, 7'h00, CID_END_BIT};
  assign card_config_reg = CONFIG_VALUE;

  always_comb begin
    ocr_ready = OCR_RESET;
    ocr_ready[OCR_WIN_HI:OCR_WIN_LO] = OCR_WIN_VAL;
    ocr_ready[OCR_LOW_VOLTAGE_SWITCH_ACCEPTED_BIT] = OCR_LOW_VOLTAGE_SWITCH_ACCEPTED_VAL;
    ocr_ready[OCR_CCS_BIT] = OCR_CCS_VAL;
  end

  // ****************************************************************************
  // Identity checksum engine
  // ****************************************************************************
  logic [CID_BODY_W-1:0] crc_shift;
  logic [CID_BODY_W-1:0] next_crc_shift;
  logic [CRC_W-1:0] cid_crc;
  logic [CRC_W-1:0] next_cid_crc;
  logic [6:0] crc_cnt;
  logic [6:0] next_crc_cnt;
  logic next_id_check_ready;
  logic crc_fb;

  always_comb begin
    next_crc_shift = crc_shift;
    next_cid_crc = cid_crc;
    next_crc_cnt = crc_cnt;
    next_id_check_ready = id_check_ready;
    crc_fb = crc_shift[CID_BODY_W-1] ^ cid_crc[CRC_W-1];
    if (!id_check_ready) begin
      next_crc_shift = {crc_shift[CID_BODY_W-2:0], 1'h0};
      next_cid_crc = {cid_crc[CRC_W-2:0], 1'h0} ^ (crc_fb ? CRC7_POLY : CRC7_INIT);
      next_crc_cnt = crc_cnt + 7'h01;
      next_id_check_ready = (next_crc_cnt == CRC_CNT_LAST);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      crc_shift <= cid_body;
      cid_crc <= CRC7_INIT;
      crc_cnt <= CRC_CNT_INIT;
      id_check_ready <= 1'h0;
    end else begin
      crc_shift <= next_crc_shift;
      cid_crc <= next_cid_crc;
      crc_cnt <= next_crc_cnt;
      id_check_ready <= next_id_check_ready;
    end
  end

  assign card_identity_reg = {cid_body, cid_crc, CID_END_BIT};

  // ****************************************************************************
  // Operating conditions and busy flag
  // ****************************************************************************
  logic [OCR_W-1:0] next_ocr;

  always_comb begin
    next_ocr = ocr_ready;
    next_ocr[OCR_BUSY_BIT] = operating_conditions_reg[OCR_BUSY_BIT] | (init_done & id_check_ready);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      operating_conditions_reg <= OCR_RESET;
    end else begin
      operating_conditions_reg <= next_ocr;
    end
  end

  // ****************************************************************************
  // Writable fields: card data and relative address
  // ****************************************************************************
  logic csd_copy;
  logic csd_perm;
  logic csd_tmp;
  logic [CRC_W-1:0] csd_crc;
  logic next_csd_copy;
  logic next_csd_perm;
  logic next_csd_tmp;
  logic [CRC_W-1:0] next_csd_crc;
  logic [RCA_W-1:0] next_rca;
  logic next_wr_done;
  logic next_wr_error;

  always_comb begin
    card_specific_data_reg = csd_fixed;
    card_specific_data_reg[CSD_COPY_BIT] = csd_copy;
    card_specific_data_reg[CSD_PERM_BIT] = csd_perm;
    card_specific_data_reg[CSD_TMP_BIT] = csd_tmp;
    card_specific_data_reg[CSD_CRC_HI:CSD_CRC_LO] = csd_crc;
  end

  always_comb begin
    next_csd_copy = csd_copy;
    next_csd_perm = csd_perm;
    next_csd_tmp = csd_tmp;
    next_csd_crc = csd_crc;
    next_rca = relative_address_reg;
    next_wr_done = 1'h0;
    next_wr_error = 1'h0;
    if (wr_req) begin
      next_wr_done = 1'h1;
      case (wr_sel)
        SDREG_SEL_CSD: begin
          if ((wr_data & ~CSD_WR_MASK) != (card_specific_data_reg & ~CSD_WR_MASK)) begin
            next_wr_error = 1'h1;
          end else begin
            next_csd_copy = csd_copy | wr_data[CSD_COPY_BIT];
            next_csd_perm = csd_perm | wr_data[CSD_PERM_BIT];
            next_csd_tmp = wr_data[CSD_TMP_BIT];
            next_csd_crc = wr_data[CSD_CRC_HI:CSD_CRC_LO];
          end
        end
        SDREG_SEL_RCA: begin
          next_rca = wr_data[RCA_W-1:0];
        end
        default: begin
          next_wr_error = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      csd_copy <= 1'h0;
      csd_perm <= 1'h0;
      csd_tmp <= 1'h0;
      csd_crc <= CSD_CRC_INIT;
      relative_address_reg <= RCA_RESET;
      wr_done <= 1'h0;
      wr_error <= 1'h0;
    end else begin
      csd_copy <= next_csd_copy;
      csd_perm <= next_csd_perm;
      csd_tmp <= next_csd_tmp;
      csd_crc <= next_csd_crc;
      relative_address_reg <= next_rca;
      wr_done <= next_wr_done;
      wr_error <= next_wr_error;
    end
  end

  // ****************************************************************************
  // Read port
  // ****************************************************************************
  logic [CID_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic next_rd_refused;

  always_comb begin
    next_rd_data = DATA_ZERO;
    next_rd_valid = rd_req;
    next_rd_refused = 1'h0;
    if (rd_req) begin
      case (rd_sel)
        SDREG_SEL_OCR: next_rd_data = {96'h0, operating_conditions_reg};
        SDREG_SEL_CID: next_rd_data = card_identity_reg;
        SDREG_SEL_CSD: next_rd_data = card_specific_data_reg;
        SDREG_SEL_RCA: next_rd_data = {112'h0, relative_address_reg};
        SDREG_SEL_CFG: next_rd_data = {64'h0, card_config_reg};
        SDREG_SEL_STAT: next_rd_data = STATUS_VALUE[rd_index*CID_W +: CID_W];
        default: next_rd_refused = 1'h1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= DATA_ZERO;
      rd_valid <= 1'h0;
      rd_refused <= 1'h0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_refused <= next_rd_refused;
    end
  end

endmodule

// File: test/sdreg_bank_asserts.sv
// Port checker for the card register bank.
// Assumes it is bound to sdreg_bank and sees only its ports.
`timescale 1ns/1ps
module sdreg_bank_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Requests
  input wire logic init_done,
  input wire logic rd_req,
  input wire sdreg_pkg::sdreg_sel_t rd_sel,
  input wire logic wr_req,
  input wire sdreg_pkg::sdreg_sel_t wr_sel,
  input wire logic [127:0] wr_data,
  // Answers and views
  input wire logic rd_valid,
  input wire logic rd_refused,
  input wire logic [127:0] rd_data,
  input wire logic wr_done,
  input wire logic wr_error,
  input wire logic [31:0] operating_conditions_reg,
  input wire logic [15:0] relative_address_reg,
  input wire logic id_check_ready
);
  import sdreg_pkg::*;
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [31:0] operating_conditions;
  logic [15:0] wr_lo;
  assign operating_conditions = operating_conditions_reg;
  assign wr_lo = wr_data[15:0];
  property p_win; !$past(reset) |-> operating_conditions[23:15] == 9'h1ff; endproperty
  a_win: assert property (p_win) else $error("voltage window wrong");
  property p_rsv; !$past(reset) |-> operating_conditions[30:24] == 7'h0 && operating_conditions[14:0] == 15'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("zero bits of ocr set");
  property p_bsrc; $rose(operating_conditions[31]) |-> $past(init_done) && $past(id_check_ready); endproperty
  a_bsrc: assert property (p_bsrc) else $error("busy flag set early");
  property p_bset; init_done && id_check_ready |=> operating_conditions[31]; endproperty
  a_bset: assert property (p_bset) else $error("busy flag not set");
  property p_ocr; !$past(reset) && rd_req && rd_sel == SDREG_SEL_OCR |=>
    rd_valid && rd_data[127:32] == 96'h0 && rd_data[23:15] == 9'h1ff; endproperty
  a_ocr: assert property (p_ocr) else $error("ocr read wrong");
  property p_ans; rd_valid |-> $past(rd_req); endproperty
  a_ans: assert property (p_ans) else $error("read answer without request");
  property p_dsr; rd_req && rd_sel == SDREG_SEL_DSR |=> rd_valid && rd_refused && rd_data == 128'h0; endproperty
  a_dsr: assert property (p_dsr) else $error("driver stage read not refused");
  property p_csd; rd_req && rd_sel == SDREG_SEL_CSD |=> rd_data[127:126] == 2'h1 && rd_data[119:112] == 8'h0e
    && rd_data[83:80] == 4'h9 && rd_data[46] && rd_data[45:39] == 7'h7f; endproperty
  a_csd: assert property (p_csd) else $error("csd fixed field wrong");
  property p_cid; rd_req && rd_sel == SDREG_SEL_CID |=> rd_data[23:20] == 4'h0 && rd_data[0]; endproperty
  a_cid: assert property (p_cid) else $error("cid fixed bits wrong");
  property p_wbad; wr_req && !(wr_sel inside {SDREG_SEL_CSD, SDREG_SEL_RCA}) |=> wr_done && wr_error; endproperty
  a_wbad: assert property (p_wbad) else $error("read-only write accepted");
  property p_rca; wr_req && wr_sel == SDREG_SEL_RCA |=>
    wr_done && !wr_error && relative_address_reg == $past(wr_lo); endproperty
  a_rca: assert property (p_rca) else $error("address write lost");
  c_busy: cover property ($rose(operating_conditions[31]));
  c_refuse: cover property (rd_refused);
  c_wr_err: cover property (wr_done && wr_error);
endmodule

// File: test/sdreg_host_model.sv
// Host-side model issuing register reads and writes.
// Assumes one clock with the bank; drives on the falling edge.
`timescale 1ns/1ps
module sdreg_host_model (
  // Clock
  input wire logic core_clk,
  // Read port
  output logic rd_req,
  output sdreg_pkg::sdreg_sel_t rd_sel,
  output logic [1:0] rd_index,
  input wire logic rd_valid,
  input wire logic rd_refused,
  input wire logic [127:0] rd_data,
  // Write port
  output logic wr_req,
  output sdreg_pkg::sdreg_sel_t wr_sel,
  output logic [127:0] wr_data,
  input wire logic wr_done,
  input wire logic wr_error
);
  import sdreg_pkg::*;
  // ****
  // Bus cycles
  // ****
  initial begin
    rd_req = 1'b0;
    rd_sel = SDREG_SEL_OCR;
    rd_index = 2'h0;
    wr_req = 1'b0;
    wr_sel = SDREG_SEL_OCR;
    wr_data = 128'h0;
  end
  task automatic rd(input sdreg_sel_t s, input logic [1:0] i, output logic [127:0] d, output logic rf);
    @(negedge core_clk);
    rd_req = 1'b1;
    rd_sel = s;
    rd_index = i;
    @(negedge core_clk);
    d = rd_valid ? rd_data : 128'hx;
    rf = rd_refused;
    rd_req = 1'b0;
    rd_index = ~i;
  endtask
  task automatic wr(input sdreg_sel_t s, input logic [127:0] d, output logic err);
    @(negedge core_clk);
    wr_req = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(negedge core_clk);
    err = wr_done ? wr_error : 1'bx;
    wr_req = 1'b0;
    wr_data = ~d;
  endtask
  task automatic poll(output logic ok);
    logic [127:0] d;
    logic rf;
    ok = 1'b0;
    for (int n = 0; n < 200 && ok !== 1'b1; n++) begin
      rd(SDREG_SEL_OCR, 2'h0, d, rf);
      ok = d[31];
    end
  endtask
endmodule

// File: test/sdreg_bank_tb.sv
// Self-checking bench for the card register bank.
// Assumes the host model drives all request ports.
`timescale 1ns/1ps
module sdreg_bank_tb;
  import sdreg_pkg::*;
  // ****
  // Bench
  // ****
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [31:0] SERIAL = 32'h0bad_1234;
  localparam logic [63:0] CFG = 64'h0123_4567_89ab_cdef;
  logic core_clk, reset, init_done, rd_req, rd_valid, rd_refused, wr_req, wr_done, wr_error, id_check_ready;
  sdreg_sel_t rd_sel, wr_sel;
  logic [1:0] rd_index;
  logic [127:0] rd_data, wr_data, d;
  logic [127:0] rd_data_q;
  logic [31:0] operating_conditions_reg;
  logic [15:0] relative_address_reg;
  logic rf, e, ok;
  int fails, n_compared;
  sdreg_bank #(.MAKER_CODE(MAKER), .SERIAL_NUMBER(SERIAL), .CONFIG_VALUE(CFG),
    .STATUS_VALUE({128'h4, 128'h3, 128'h2, 128'h1})) u_sdreg_bank (.core_clk, .reset, .init_done,
    .rd_req, .rd_sel, .rd_index, .rd_valid, .rd_refused, .rd_data, .wr_req, .wr_sel, .wr_data, .wr_done,
    .wr_error, .operating_conditions_reg, .relative_address_reg, .id_check_ready);
  sdreg_host_model u_sdreg_host_model (.core_clk, .rd_req, .rd_sel, .rd_index, .rd_valid, .rd_refused,
    .rd_data, .wr_req, .wr_sel, .wr_data, .wr_done, .wr_error);
  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_ocr();
    u_sdreg_host_model.rd(SDREG_SEL_OCR, 2'h0, d, rf);
    chk("ocr busy", 128'h00ff_8000, d);
    init_done = 1'b1;
    u_sdreg_host_model.poll(ok);
    chk("poll ready", 128'h1, 128'(ok));
    chk("id check ready", 128'h1, 128'(id_check_ready));
    if (ok !== 1'b1) end_of_test();
    u_sdreg_host_model.rd(SDREG_SEL_OCR, 2'h0, d, rf);
    chk("ocr ready", 128'h80ff_8000, d);
  endtask
  task automatic t_cid();
    u_sdreg_host_model.rd(SDREG_SEL_CID, 2'h0, d, rf);
    chk("cid maker", 128'(MAKER), 128'(d[127:120]));
    chk("cid serial", 128'(SERIAL), 128'(d[55:24]));
    chk("cid fixed", 128'h1, 128'({d[23:20], d[0]}));
  endtask
  task automatic t_csd();
    u_sdreg_host_model.rd(SDREG_SEL_CSD, 2'h0, d, rf);
    chk("csd fixed", 128'({2'h1, 8'h0e, 4'h9, 1'h1, 7'h7f}),
      128'({d[127:126], d[119:112], d[83:80], d[46], d[45:39]}));
    d = d | 128'h1000;
    u_sdreg_host_model.wr(SDREG_SEL_CSD, d, e);
    chk("csd tmp accepted", 128'h0, 128'(e));
    u_sdreg_host_model.wr(SDREG_SEL_CSD, d ^ (128'h1 << 127), e);
    chk("csd ro refused", 128'h1, 128'(e));
    u_sdreg_host_model.rd(SDREG_SEL_CSD, 2'h0, rd_data_q, rf);
    chk("csd image", d, rd_data_q);
  endtask
  task automatic t_misc();
    u_sdreg_host_model.rd(SDREG_SEL_DSR, 2'h0, d, rf);
    chk("dsr refused", 128'h1, {d[127:1], rf});
    u_sdreg_host_model.wr(SDREG_SEL_OCR, 128'h0, e);
    chk("ocr write refused", 128'h1, 128'(e));
    u_sdreg_host_model.rd(SDREG_SEL_CFG, 2'h0, d, rf);
    chk("config", 128'(CFG), d);
    for (int i = 0; i < 4; i++) begin
      u_sdreg_host_model.rd(SDREG_SEL_STAT, 2'(i), d, rf);
      chk("status chunk", 128'(i + 1), d);
    end
    u_sdreg_host_model.wr(SDREG_SEL_RCA, 128'h1234, e);
    chk("rca port", 128'h1234, 128'(relative_address_reg));
    chk("rca write error", 128'h0, 128'(e));
    u_sdreg_host_model.rd(SDREG_SEL_RCA, 2'h0, d, rf);
    chk("rca read", 128'h1234, d);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    fails = 0;
    n_compared = 0;
    reset = 1'b1;
    init_done = 1'b0;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    t_ocr();
    t_cid();
    t_csd();
    t_misc();
    end_of_test();
  end
endmodule
bind sdreg_bank sdreg_bank_asserts u_sdreg_bank_asserts (.core_clk, .reset, .init_done, .rd_req, .rd_sel,
  .wr_req, .wr_sel, .wr_data, .rd_valid, .rd_refused, .rd_data, .wr_done, .wr_error,
  .operating_conditions_reg, .relative_address_reg, .id_check_ready);
